// *** src/tdm_map.svh ***
// register map, field positions, reset values and timing of the dialer code and mute block
// What this block does
// - pulse mode emits code-valued pulse count
// - code ten dials zero, ten pulses
// - tone code selects keypad row, column
// - each nonzero code write in tone mode starts new tone
// - single tone outputs row or column
// - dual tone combines row and column
// - receive select zero holds receive mute low
// - receive select one mutes during pulse, flash
// - transmit select zero holds transmit mute low
// - transmit select one mutes during dialing cycles
// - hook bit one drives pulse pin high except during breaks
// - hook bit resets to zero, on-hook
`ifndef TDM_MAP_SVH
`define TDM_MAP_SVH
// ==========================================
// register offsets
`define TDM_CTRL_OFS 16'hff18
`define TDM_CODE_OFS 16'hff1c
`define TDM_MODE_OFS 16'hff20
`define TDM_STAT_OFS 16'hff24
// ==========================================
// control fields
`define TDM_TXSEL_BIT 0
`define TDM_RXSEL_BIT 1
`define TDM_HOOK_BIT 2
`define TDM_TXSEL_RST 1'h1
`define TDM_RXSEL_RST 1'h1
`define TDM_HOOK_RST 1'h0
// ==========================================
// mode fields
`define TDM_TONE_BIT 0
`define TDM_DUAL_BIT 1
`define TDM_COLSEL_BIT 2
`define TDM_MODE_RST 3'h0
// ==========================================
// timing
`define TDM_CLK_HZ 20000000
`define TDM_BREAK_MS 60
`define TDM_MAKE_MS 40
`define TDM_TONE_MS 94
`define TDM_CYC(ms) ((ms) * (`TDM_CLK_HZ / 1000))
`endif

// *** src/tdm_pkg.sv ***
// types shared by the dialer code and mute block
package tdm_pkg;
   typedef enum logic [1:0] {
      TDM_IDLE = 2'h0,
      TDM_BREAK = 2'h1,
      TDM_MAKE = 2'h3
   } tdm_pulse_e;
   typedef struct packed {
      logic [1:0] row;
      logic [1:0] col;
   } tdm_key_s;
   typedef struct packed {
      logic row_en;
      logic col_en;
      logic [1:0] row;
      logic [1:0] col;
   } tdm_tone_s;
endpackage : tdm_pkg

// *** src/tdm_dialer.sv ***
// dial code, tone select, mute and hook logic behind an axi4-lite slave
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tdm_map.svh"
module tdm_dialer
   import tdm_pkg::*;
#(
   parameter int BREAK_CYCLES = `TDM_CYC(`TDM_BREAK_MS),
   parameter int MAKE_CYCLES = `TDM_CYC(`TDM_MAKE_MS),
   parameter int TONE_CYCLES = `TDM_CYC(`TDM_TONE_MS)
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic flash_cycle,
   input wire logic hold_cycle,
   output logic dial_pulse_out_n,
   output logic receive_mute_out_n,
   output logic transmit_mute_out_n,
   output tdm_tone_s tone_out
);
   // ==========================================
   // parameter checks
   if (BREAK_CYCLES < 1 || MAKE_CYCLES < 1 || TONE_CYCLES < 1) begin : g_bad_timing
      $error("tdm_dialer: timing counts must be at least one");
   end
   if (BREAK_CYCLES >= 2**24 || MAKE_CYCLES >= 2**24 || TONE_CYCLES >= 2**24) begin : g_big_timing
      $error("tdm_dialer: timing counts exceed timer width");
   end

   localparam logic [23:0] BRK_C = 24'(BREAK_CYCLES - 1);
   localparam logic [23:0] MK_C = 24'(MAKE_CYCLES - 1);
   localparam logic [23:0] TONE_C = 24'(TONE_CYCLES - 1);

   // ==========================================
   // keypad lookup, zero-based row and column
   function automatic tdm_key_s key_of(input logic [3:0] code);
      tdm_key_s k;
      k = '{row: 2'h0, col: 2'h3};
      case (code)
         4'h1: k = '{row: 2'h0, col: 2'h0};
         4'h2: k = '{row: 2'h0, col: 2'h1};
         4'h3: k = '{row: 2'h0, col: 2'h2};
         4'h4: k = '{row: 2'h1, col: 2'h0};
         4'h5: k = '{row: 2'h1, col: 2'h1};
         4'h6: k = '{row: 2'h1, col: 2'h2};
         4'h7: k = '{row: 2'h2, col: 2'h0};
         4'h8: k = '{row: 2'h2, col: 2'h1};
         4'h9: k = '{row: 2'h2, col: 2'h2};
         4'ha: k = '{row: 2'h3, col: 2'h1};
         4'hb: k = '{row: 2'h3, col: 2'h2};
         4'hc: k = '{row: 2'h3, col: 2'h0};
         4'hd: k = '{row: 2'h1, col: 2'h3};
         4'he: k = '{row: 2'h2, col: 2'h3};
         4'hf: k = '{row: 2'h3, col: 2'h3};
         default: k = '{row: 2'h0, col: 2'h3};
      endcase
      return k;
   endfunction : key_of

   // ==========================================
   // state
   logic aw_ok_reg, aw_ok_next;
   logic w_ok_reg, w_ok_next;
   logic [15:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic wlane_reg, wlane_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic txsel_reg, txsel_next;
   logic rxsel_reg, rxsel_next;
   logic hook_reg, hook_next;
   logic [2:0] mode_reg, mode_next;
   tdm_pulse_e pstate_reg, pstate_next;
   logic [3:0] left_reg, left_next;
   logic [23:0] ptimer_reg, ptimer_next;
   logic tone_busy_reg, tone_busy_next;
   logic [23:0] ttimer_reg, ttimer_next;
   tdm_tone_s tone_reg, tone_next;
   logic dp_reg, dp_next;
   logic rxm_reg, rxm_next;
   logic txm_reg, txm_next;

   logic do_write;
   logic pulse_busy;
   tdm_key_s key;

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign dial_pulse_out_n = dp_reg;
   assign receive_mute_out_n = rxm_reg;
   assign transmit_mute_out_n = txm_reg;
   assign tone_out = tone_reg;

   // ==========================================
   // next-state logic
   always_comb begin
      aw_ok_next = aw_ok_reg;
      w_ok_next = w_ok_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wlane_next = wlane_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      txsel_next = txsel_reg;
      rxsel_next = rxsel_reg;
      hook_next = hook_reg;
      mode_next = mode_reg;
      pstate_next = pstate_reg;
      left_next = left_reg;
      ptimer_next = ptimer_reg;
      tone_busy_next = tone_busy_reg;
      ttimer_next = ttimer_reg;
      tone_next = tone_reg;
      pulse_busy = (pstate_reg != TDM_IDLE);
      key = key_of(wdata_reg[3:0]);

      // write address and data taken in either order
      if (s_axi_awvalid && awready_reg) begin
         aw_ok_next = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
         w_ok_next = 1'b1;
         wdata_next = s_axi_wdata;
         wlane_next = s_axi_wstrb[0];
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end

      // pulse generator
      case (pstate_reg)
         TDM_IDLE: begin
         end
         TDM_BREAK: begin
            if (ptimer_reg == 24'h0) begin
               pstate_next = TDM_MAKE;
               ptimer_next = MK_C;
               left_next = left_reg - 4'h1;
            end else begin
               ptimer_next = ptimer_reg - 24'h1;
            end
         end
         TDM_MAKE: begin
            if (ptimer_reg != 24'h0) begin
               ptimer_next = ptimer_reg - 24'h1;
            end else if (left_reg != 4'h0) begin
               pstate_next = TDM_BREAK;
               ptimer_next = BRK_C;
            end else begin
               pstate_next = TDM_IDLE;
            end
         end
         default: pstate_next = TDM_IDLE;
      endcase

      // tone duration
      if (tone_busy_reg) begin
         if (ttimer_reg == 24'h0) begin
            tone_busy_next = 1'b0;
            tone_next.row_en = 1'b0;
            tone_next.col_en = 1'b0;
         end else begin
            ttimer_next = ttimer_reg - 24'h1;
         end
      end

      // register write, once address and data are both held
      do_write = aw_ok_reg && w_ok_reg && !bvalid_reg;
      if (do_write) begin
         aw_ok_next = 1'b0;
         w_ok_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = 2'h0;
         case (awaddr_reg)
            `TDM_CTRL_OFS: if (wlane_reg) begin
               txsel_next = wdata_reg[`TDM_TXSEL_BIT];
               rxsel_next = wdata_reg[`TDM_RXSEL_BIT];
               hook_next = wdata_reg[`TDM_HOOK_BIT];
            end
            `TDM_MODE_OFS: if (wlane_reg) begin
               mode_next = wdata_reg[2:0];
            end
            `TDM_CODE_OFS: if (wlane_reg && wdata_reg[3:0] != 4'h0) begin
               if (mode_reg[`TDM_TONE_BIT]) begin
                  tone_busy_next = 1'b1;
                  ttimer_next = TONE_C;
                  tone_next.row = key.row;
                  tone_next.col = key.col;
                  tone_next.row_en = mode_reg[`TDM_DUAL_BIT] | ~mode_reg[`TDM_COLSEL_BIT];
                  tone_next.col_en = mode_reg[`TDM_DUAL_BIT] | mode_reg[`TDM_COLSEL_BIT];
               end else if (!pulse_busy) begin
                  pstate_next = TDM_BREAK;
                  ptimer_next = BRK_C;
                  left_next = wdata_reg[3:0];
               end
            end
            `TDM_STAT_OFS: begin
            end
            default: bresp_next = 2'h2;
         endcase
      end

      // read channel
      if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
      if (s_axi_arvalid && arready_reg) begin
         rvalid_next = 1'b1;
         rresp_next = 2'h0;
         rdata_next = 32'h0;
         case (s_axi_araddr)
            `TDM_CTRL_OFS: begin
               rdata_next[`TDM_TXSEL_BIT] = txsel_reg;
               rdata_next[`TDM_RXSEL_BIT] = rxsel_reg;
               rdata_next[`TDM_HOOK_BIT] = hook_reg;
            end
            `TDM_MODE_OFS: rdata_next[2:0] = mode_reg;
            `TDM_CODE_OFS: begin
            end
            `TDM_STAT_OFS: begin
               rdata_next[0] = pulse_busy;
               rdata_next[1] = tone_busy_reg;
               rdata_next[7:4] = left_reg;
               rdata_next[8] = dp_reg;
               rdata_next[9] = rxm_reg;
               rdata_next[10] = txm_reg;
            end
            default: rresp_next = 2'h2;
         endcase
      end

      awready_next = !aw_ok_next && !bvalid_next;
      wready_next = !w_ok_next && !bvalid_next;
      arready_next = !rvalid_next;

      // pins
      dp_next = hook_reg && (pstate_reg != TDM_BREAK);
      rxm_next = rxsel_reg && !pulse_busy && !flash_cycle;
      txm_next = txsel_reg && !pulse_busy && !flash_cycle && !tone_busy_next && !hold_cycle;
   end

   // ==========================================
   // registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         aw_ok_reg <= 1'b0;
         w_ok_reg <= 1'b0;
         awaddr_reg <= 16'h0;
         wdata_reg <= 32'h0;
         wlane_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= 2'h0;
         txsel_reg <= `TDM_TXSEL_RST;
         rxsel_reg <= `TDM_RXSEL_RST;
         hook_reg <= `TDM_HOOK_RST;
         mode_reg <= `TDM_MODE_RST;
         pstate_reg <= TDM_IDLE;
         left_reg <= 4'h0;
         ptimer_reg <= 24'h0;
         tone_busy_reg <= 1'b0;
         ttimer_reg <= 24'h0;
         tone_reg <= '0;
         dp_reg <= 1'b0;
         rxm_reg <= 1'b1;
         txm_reg <= 1'b1;
      end else begin
         aw_ok_reg <= aw_ok_next;
         w_ok_reg <= w_ok_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wlane_reg <= wlane_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         txsel_reg <= txsel_next;
         rxsel_reg <= rxsel_next;
         hook_reg <= hook_next;
         mode_reg <= mode_next;
         pstate_reg <= pstate_next;
         left_reg <= left_next;
         ptimer_reg <= ptimer_next;
         tone_busy_reg <= tone_busy_next;
         ttimer_reg <= ttimer_next;
         tone_reg <= tone_next;
         dp_reg <= dp_next;
         rxm_reg <= rxm_next;
         txm_reg <= txm_next;
      end
   end
endmodule : tdm_dialer

// *** verification/tdm_dialer_sva.sv ***
// checker for the dialer code and mute block
`timescale 1ns/1ps
module tdm_dialer_sva
   import tdm_pkg::*;
#(
   parameter int BREAK_CYCLES = 3,
   parameter int MAKE_CYCLES = 2,
   parameter int TONE_CYCLES = 5
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic flash_cycle,
   input wire logic hold_cycle,
   input wire logic receive_mute_out_n,
   input wire logic transmit_mute_out_n,
   input wire tdm_tone_s tone_out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ==========
   // bus handshake
   property p_b_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("write response missing");
   property p_b_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_b_block: assert property (p_b_block) else $error("write taken during response");
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("read data missing");
   property p_r_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_r_block: assert property (p_r_block) else $error("read taken during data");
   // ==========
   // mute lines
   property p_flash_rx;
      $rose(flash_cycle) |-> ##[1:2] !receive_mute_out_n;
   endproperty
   a_flash_rx: assert property (p_flash_rx) else $error("rx not muted in flash");
   property p_flash_tx;
      $rose(flash_cycle) |-> ##[1:2] !transmit_mute_out_n;
   endproperty
   a_flash_tx: assert property (p_flash_tx) else $error("tx not muted in flash");
   property p_hold_tx;
      $rose(hold_cycle) |-> ##[1:2] !transmit_mute_out_n;
   endproperty
   a_hold_tx: assert property (p_hold_tx) else $error("tx not muted in hold");
   property p_tone_tx;
      tone_out.row_en || tone_out.col_en |-> !transmit_mute_out_n;
   endproperty
   a_tone_tx: assert property (p_tone_tx) else $error("tx not muted in tone");
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_dual: cover property (tone_out.row_en && tone_out.col_en);
   c_flash: cover property ($rose(flash_cycle));
endmodule : tdm_dialer_sva
bind tdm_dialer tdm_dialer_sva #(.BREAK_CYCLES(BREAK_CYCLES), .MAKE_CYCLES(MAKE_CYCLES),
   .TONE_CYCLES(TONE_CYCLES)) u_sva (.ref_clk(ref_clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .flash_cycle(flash_cycle),
   .hold_cycle(hold_cycle), .receive_mute_out_n(receive_mute_out_n), .transmit_mute_out_n(transmit_mute_out_n),
   .tone_out(tone_out));

// *** verification/tdm_line_model.sv ***
// line interface model counting dial pulse breaks
`timescale 1ns/1ps
module tdm_line_model (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic dial_pulse_out_n,
   output int pulse_count
);
   logic dp_last;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         dp_last <= 1'b0;
         pulse_count <= 0;
      end else begin
         dp_last <= dial_pulse_out_n;
         if (dp_last && !dial_pulse_out_n) pulse_count <= pulse_count + 1;
      end
   end
endmodule : tdm_line_model

// *** verification/testbench.sv ***
// register level testbench of the dialer code and mute block
`timescale 1ns/1ps
`include "tdm_map.svh"
module testbench
   import tdm_pkg::*;
;
   logic ref_clk = 1'b0, rstn = 1'b0;
   logic [15:0] awaddr = 16'h0, araddr = 16'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, dp_n, rx_n, tx_n;
   logic flash = 1'b0, hold = 1'b0;
   logic [1:0] bresp, rresp, last_b, last_r;
   tdm_tone_s tone_out;
   int pulse_count, n_fail = 0, n_checks = 0, cyc = 0, p0;
   // keypad {row,col} per code, code 15 first
   localparam logic [63:0] KEYS = 64'hfb7ceda986542103;
   always #25 ref_clk = ~ref_clk;
   tdm_dialer #(.BREAK_CYCLES(3), .MAKE_CYCLES(2), .TONE_CYCLES(5)) dut (.ref_clk(ref_clk), .rstn(rstn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .flash_cycle(flash), .hold_cycle(hold), .dial_pulse_out_n(dp_n),
      .receive_mute_out_n(rx_n), .transmit_mute_out_n(tx_n), .tone_out(tone_out));
   tdm_line_model line (.ref_clk(ref_clk), .rstn(rstn), .dial_pulse_out_n(dp_n), .pulse_count(pulse_count));
   task automatic summarize();
      if (n_fail == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      last_b = bresp;
      bready <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [31:0] v);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      v = rdata;
      last_r = rresp;
      rready <= 1'b0;
      @(posedge ref_clk);
   endtask : rd
   task automatic mutes(input logic [1:0] exp);
      chk(32'({rx_n, tx_n}), 32'(exp));
   endtask : mutes
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      rd(`TDM_CTRL_OFS, d);
      chk(d, 32'h3);
      chk(32'(dp_n), 32'h0);
      wr(`TDM_CTRL_OFS, 32'h4);
      chk(32'(dp_n), 32'h1);
      mutes(2'b00);
      wr(`TDM_CTRL_OFS, 32'h7);
      mutes(2'b11);
      rd(`TDM_CTRL_OFS, d);
      chk(d, 32'h7);
      wr(16'hff40, 32'h0);
      chk(32'(last_b), 32'h2);
      rd(16'hff40, d);
      chk(32'(last_r), 32'h2);
      chk(d, 32'h0);
      flash <= 1'b1;
      repeat (3) @(posedge ref_clk);
      mutes(2'b00);
      flash <= 1'b0;
      hold <= 1'b1;
      repeat (3) @(posedge ref_clk);
      mutes(2'b10);
      hold <= 1'b0;
      repeat (3) @(posedge ref_clk);
      mutes(2'b11);
      wr(`TDM_MODE_OFS, 32'h0);
      for (int c = 1; c <= 10; c++) begin
         p0 = pulse_count;
         wr(`TDM_CODE_OFS, 32'(c));
         mutes(2'b00);
         do rd(`TDM_STAT_OFS, d); while (d[0] !== 1'b0);
         chk(32'(pulse_count - p0), 32'(c));
         mutes(2'b11);
      end
      rd(`TDM_CODE_OFS, d);
      chk(d, 32'h0);
      wr(`TDM_MODE_OFS, 32'h3);
      for (int c = 1; c <= 15; c++) begin
         wr(`TDM_CODE_OFS, 32'(c));
         chk(32'(tone_out), 32'({2'b11, KEYS[4*c+:4]}));
         mutes(2'b10);
      end
      wr(`TDM_MODE_OFS, 32'h1);
      wr(`TDM_CODE_OFS, 32'h5);
      chk(32'(tone_out), 32'h25);
      wr(`TDM_MODE_OFS, 32'h5);
      wr(`TDM_CODE_OFS, 32'hd);
      chk(32'(tone_out), 32'h17);
      summarize();
   end
endmodule : testbench
